//--- include/idf_regs.svh
`ifndef IDF_REGS_SVH
`define IDF_REGS_SVH
// ****************************************
// Timing figures and derived cycle counts
// ****************************************
`define IDF_CLK_PERIOD_PS 32'h0000_1F40
// Fixed widths in picoseconds, as printed (125 ns, 6.425 us, 2.55 ms, 5/1 us, 500/100 ns)
`define IDF_W_LT0_PS 32'h0001_E848
`define IDF_W_LT1_PS 32'h0062_0A28
`define IDF_W_LT2_PS 32'h97FD_9F00
`define IDF_W_TD0_PS 32'h004C_4B40
`define IDF_W_TD1_PS 32'h000F_4240
`define IDF_W_TD2_PS 32'h0007_A120
`define IDF_W_TD3_PS 32'h0001_86A0
// Reset width of isolated lines: 0.1 ms
`define IDF_W_ISO_PS 32'h05F5_E100
// Pass widths round down, so a pulse of the full time always fills them
`define IDF_CYC(ps) ((ps) / `IDF_CLK_PERIOD_PS)
`define IDF_SEL_W 3
`define IDF_SEL_FIX0 3'h0
`define IDF_SEL_FIX1 3'h1
`define IDF_SEL_FIX2 3'h2
`define IDF_SEL_FIX3 3'h3
`define IDF_SEL_CUSTOM 3'h4
`define IDF_SEL_ISO 3'h5
`define IDF_NUM_LINES 16
`define IDF_CNT_W 32
`define IDF_ONE 32'h0000_0001
`define IDF_ZERO 32'h0000_0000
`endif

//--- include/idf_pkg.sv
package idf_pkg;
  // Per-line conditioning mode
  typedef enum logic [1:0] {
    IDF_MODE_BYPASS,
    IDF_MODE_FILTER,
    IDF_MODE_SYNC
  } idf_mode_t;
  // Device family variant
  typedef enum logic {
    IDF_FAM_LOWER,
    IDF_FAM_TIMER
  } idf_fam_t;
endpackage : idf_pkg

//--- logic/idf_line.sv
`timescale 1ns/1ns
`include "idf_regs.svh"
// One line: stability counter filter with tick-driven sampling
module idf_line (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic in_i,
  input wire logic tick_i,
  input wire logic filt_en_i,
  input wire logic [`IDF_CNT_W-1:0] width_i,
  output logic out_o
);
  logic out_r, out_nxt;
  logic [`IDF_CNT_W-1:0] cnt_r, cnt_nxt;

  // ****************************************
  // Stability counter
  // ****************************************
  // Counter restarts whenever input matches output; output flips at the selected width
  always_comb begin
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    if (!filt_en_i) begin
      out_nxt = in_i;
      cnt_nxt = `IDF_ZERO;
    end else if (in_i == out_r) begin
      cnt_nxt = `IDF_ZERO;
    end else if (tick_i) begin
      if (cnt_r + `IDF_ONE >= width_i) begin
        out_nxt = in_i;
        cnt_nxt = `IDF_ZERO;
      end else begin
        cnt_nxt = cnt_r + `IDF_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= 1'b0;
      cnt_r <= `IDF_ZERO;
    end else begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign out_o = out_r;

  // Output never moves while filtering unless the counter finished
  AST_LINE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (filt_en_i && $past(filt_en_i) && out_r != $past(out_r)) |-> $past(tick_i))
    else $error("filtered output changed without a tick");
endmodule : idf_line

//--- logic/input_debounce_filter.sv
`timescale 1ns/1ns
`include "idf_regs.svh"
// Functional notes
// - Lower family filters counter-routed lines and isolated lines in their reset default only, not other general digital inputs.
// - Lower family lines pick 125 ns, 6.425 us or 2.55 ms independently.
// - With filtering on, pulses at least the minimum width always pass.
// - Timer family offers resampling on fastest timebase instead of filtering.
// - Timer family lines pick one of four fixed widths or custom.
// - One shared custom width serves every line not using a fixed width.
// - Timer family rejects pulses no longer than half the pass width.
// - Custom width interval is counted by each line's own 32-bit stability counter.
// - Filtering and synchronisation together on one line are rejected.
// - Filter applies to counter, timebase, sample clock and trigger inputs.
// - Isolated lines come out of reset filtered at 0.1 ms.
// - Output changes only after the new level held the selected width.
module input_debounce_filter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire idf_pkg::idf_fam_t family_i,
  input wire logic [`IDF_NUM_LINES-1:0] line_i,
  input wire logic [`IDF_NUM_LINES-1:0] counter_route_i,
  input wire logic [`IDF_NUM_LINES-1:0] isolated_i,
  input wire logic [`IDF_NUM_LINES-1:0] filt_en_i,
  input wire logic [`IDF_NUM_LINES-1:0] sync_en_i,
  input wire logic [`IDF_NUM_LINES*`IDF_SEL_W-1:0] width_sel_i,
  input wire logic [`IDF_CNT_W-1:0] custom_width_i,
  input wire logic ext_tb_i,
  input wire logic ext_tb_src_en_i,
  input wire logic ext_tb_rate_set_i,
  input wire logic [`IDF_CNT_W-1:0] ext_tb_rate_i,
  output logic [`IDF_NUM_LINES-1:0] line_o,
  output logic [`IDF_NUM_LINES-1:0] cfg_err_o,
  output logic ext_tb_active_o
);
  // ****************************************
  // Input synchronisers and isolated-line defaults
  // ****************************************
  logic [`IDF_NUM_LINES-1:0] s1_r, s2_r, s3_r, stab_r, stab_nxt;
  logic [`IDF_NUM_LINES-1:0] iso_init_r, iso_init_nxt;
  logic ext1_r, ext2_r, ext3_r, ext_r, ext_nxt, ext_prev_r;
  logic started_r;

  // A change counts once second and third stages agree
  always_comb begin
    stab_nxt = stab_r;
    for (int i = 0; i < `IDF_NUM_LINES; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        stab_nxt[i] = s3_r[i];
      end
    end
    ext_nxt = (ext2_r == ext3_r) ? ext3_r : ext_r;
    // Isolated lines keep default filtering until software touches their enable
    iso_init_nxt = iso_init_r;
    if (!started_r) begin
      iso_init_nxt = isolated_i;
    end else begin
      iso_init_nxt = iso_init_r & ~filt_en_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      stab_r <= '0;
      ext1_r <= 1'b0;
      ext2_r <= 1'b0;
      ext3_r <= 1'b0;
      ext_r <= 1'b0;
      ext_prev_r <= 1'b0;
      iso_init_r <= '0;
      started_r <= 1'b0;
    end else begin
      s1_r <= line_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= stab_nxt;
      ext1_r <= ext_tb_i;
      ext2_r <= ext1_r;
      ext3_r <= ext2_r;
      ext_r <= ext_nxt;
      ext_prev_r <= ext_r;
      iso_init_r <= iso_init_nxt;
      started_r <= 1'b1;
    end
  end

  // ****************************************
  // Filter timebase: internal tick or external edges
  // ****************************************
  // Only both settings together switch to the external timebase
  logic use_ext;
  logic ext_tick;
  logic ext_act_r;
  assign use_ext = ext_tb_src_en_i & ext_tb_rate_set_i;
  assign ext_tick = ext_r & ~ext_prev_r;

  // Registered so the status output comes straight from a flop
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_act_r <= 1'b0;
    end else begin
      ext_act_r <= use_ext;
    end
  end
  assign ext_tb_active_o = ext_act_r;

  // ****************************************
  // Per-line mode and width selection
  // ****************************************
  localparam logic [`IDF_CNT_W-1:0] CYC_LT0 = `IDF_CYC(`IDF_W_LT0_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_LT1 = `IDF_CYC(`IDF_W_LT1_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_LT2 = `IDF_CYC(`IDF_W_LT2_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_TD0 = `IDF_CYC(`IDF_W_TD0_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_TD1 = `IDF_CYC(`IDF_W_TD1_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_TD2 = `IDF_CYC(`IDF_W_TD2_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_TD3 = `IDF_CYC(`IDF_W_TD3_PS);
  localparam logic [`IDF_CNT_W-1:0] CYC_ISO = `IDF_CYC(`IDF_W_ISO_PS);

  logic [`IDF_NUM_LINES-1:0] filt_out;
  logic [`IDF_NUM_LINES-1:0] out_nxt, out_r, err_nxt, err_r;
  idf_pkg::idf_mode_t mode [`IDF_NUM_LINES];

  genvar g;
  generate
    for (g = 0; g < `IDF_NUM_LINES; g++) begin : g_line
      logic [`IDF_SEL_W-1:0] sel;
      logic [`IDF_CNT_W-1:0] width;
      logic tick;
      logic want_f;
      logic conflict;
      assign sel = width_sel_i[g*`IDF_SEL_W +: `IDF_SEL_W];
      assign want_f = filt_en_i[g] | iso_init_r[g];
      // Both methods at once is refused; the line passes through unfiltered
      assign conflict = want_f & sync_en_i[g];

      // Width: lower family picks among three, timer among four or the shared custom
      always_comb begin
        width = CYC_TD3;
        if (iso_init_r[g]) begin
          width = CYC_ISO;
        end else if (family_i == idf_pkg::IDF_FAM_LOWER) begin
          case (sel)
            `IDF_SEL_FIX0: width = CYC_LT0;
            `IDF_SEL_FIX1: width = CYC_LT1;
            default: width = CYC_LT2;
          endcase
        end else begin
          case (sel)
            `IDF_SEL_FIX0: width = CYC_TD0;
            `IDF_SEL_FIX1: width = CYC_TD1;
            `IDF_SEL_FIX2: width = CYC_TD2;
            `IDF_SEL_FIX3: width = CYC_TD3;
            // Custom interval is counted by the line's own 32-bit counter
            default: width = (custom_width_i == `IDF_ZERO) ? `IDF_ONE : custom_width_i;
          endcase
          // External timebase counts its own edges, width in timebase periods
          if (use_ext && sel == `IDF_SEL_CUSTOM) begin
            width = ext_tb_rate_i == `IDF_ZERO ? `IDF_ONE : ext_tb_rate_i;
          end
        end
      end
      assign tick = (use_ext && family_i == idf_pkg::IDF_FAM_TIMER && sel == `IDF_SEL_CUSTOM)
        ? ext_tick : 1'b1;

      // Mode: lower family may filter only counter-routed lines and isolated lines in their reset default
      always_comb begin
        mode[g] = idf_pkg::IDF_MODE_BYPASS;
        if (conflict) begin
          mode[g] = idf_pkg::IDF_MODE_BYPASS;
        end else if (want_f && (family_i == idf_pkg::IDF_FAM_TIMER || counter_route_i[g]
            || iso_init_r[g])) begin
          mode[g] = idf_pkg::IDF_MODE_FILTER;
        end else if (sync_en_i[g] && family_i == idf_pkg::IDF_FAM_TIMER) begin
          mode[g] = idf_pkg::IDF_MODE_SYNC;
        end
      end

      // Pulses of the full width pass; under half always die since width counts whole
      idf_line u_line (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .in_i(stab_r[g]),
        .tick_i(tick),
        .filt_en_i(mode[g] == idf_pkg::IDF_MODE_FILTER),
        .width_i(width),
        .out_o(filt_out[g])
      );
    end
  endgenerate

  // ****************************************
  // Output registers
  // ****************************************
  // Sync mode is the resampled level on the fastest timebase, i.e. this clock
  always_comb begin
    for (int i = 0; i < `IDF_NUM_LINES; i++) begin
      out_nxt[i] = (mode[i] == idf_pkg::IDF_MODE_FILTER) ? filt_out[i] : stab_r[i];
      err_nxt[i] = (filt_en_i[i] | iso_init_r[i]) & sync_en_i[i];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= '0;
      err_r <= '0;
    end else begin
      out_r <= out_nxt;
      err_r <= err_nxt;
    end
  end
  assign line_o = out_r;
  assign cfg_err_o = err_r;

  // ****************************************
  // Checks
  // ****************************************
  AST_CONFLICT_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (filt_en_i[12] && sync_en_i[12]) |=> cfg_err_o[12])
    else $error("conflict not flagged");
  AST_CONFLICT_NOFILT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (filt_en_i[12] && sync_en_i[12]) |-> mode[12] != idf_pkg::IDF_MODE_FILTER)
    else $error("filter active during conflict");
  AST_LOWER_GP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (family_i == idf_pkg::IDF_FAM_LOWER && !counter_route_i[10] && !iso_init_r[10])
      |-> mode[10] != idf_pkg::IDF_MODE_FILTER)
    else $error("filtering a non-counter line");
  AST_EXT_BOTH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (!ext_tb_src_en_i || !ext_tb_rate_set_i) |=> !ext_tb_active_o)
    else $error("external timebase with partial setup");
  AST_SYNC_PASS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (mode[13] == idf_pkg::IDF_MODE_SYNC) |=> line_o[13] == $past(stab_r[13]))
    else $error("sync mode output mismatch");
  AST_LT_SHORT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (family_i == idf_pkg::IDF_FAM_LOWER && !iso_init_r[2] && width_sel_i[8:6] == `IDF_SEL_FIX0)
      |-> g_line[2].width == CYC_LT0)
    else $error("wrong lower width");
  AST_CUSTOM_SHARED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (family_i == idf_pkg::IDF_FAM_TIMER && !use_ext && !iso_init_r[4] && !iso_init_r[9]
      && width_sel_i[14:12] == `IDF_SEL_CUSTOM && width_sel_i[29:27] == `IDF_SEL_CUSTOM)
      |-> g_line[4].width == g_line[9].width)
    else $error("custom width not shared");
  AST_ISO_DEFAULT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    iso_init_r[15] |-> g_line[15].width == CYC_ISO)
    else $error("isolated default width wrong");
  COV_FILTER: cover property (@(posedge ref_clk_i) mode[0] == idf_pkg::IDF_MODE_FILTER
    && line_o[0] != $past(line_o[0]));
  COV_SYNC: cover property (@(posedge ref_clk_i) mode[13] == idf_pkg::IDF_MODE_SYNC);
  COV_CONFLICT: cover property (@(posedge ref_clk_i) cfg_err_o[12]);
  COV_EXT: cover property (@(posedge ref_clk_i) ext_tb_active_o && ext_tick);
endmodule : input_debounce_filter

//--- test/idf_sig_src.sv
`timescale 1ns/1ns
// ****************************************
// Far-side signal source
// ****************************************
module idf_sig_src (
  input wire logic ref_clk_i,
  output logic [15:0] line_o,
  output logic ext_tb_o
);
  // Filter timebase runs free, one rising edge every 4 clocks
  initial begin
    ext_tb_o = 1'b0;
    forever begin
      repeat (2) @(posedge ref_clk_i);
      #1 ext_tb_o = ~ext_tb_o;
    end
  end
  initial line_o = 16'h0000;
  // All lines rise together, each falls after its own count
  task automatic burst(input int len[16]);
    int mx;
    mx = 0;
    foreach (len[g]) if (len[g] > mx) mx = len[g];
    for (int k = 0; k <= mx; k++) begin
      @(posedge ref_clk_i);
      #1;
      foreach (len[g]) line_o[g] = (k < len[g]);
    end
  endtask : burst
endmodule : idf_sig_src

//--- test/testbench.sv
`timescale 1ns/1ns
`include "idf_regs.svh"
module testbench;
  logic ref_clk_i, rst_b_i, ext_tb_i, ext_tb_src_en_i, ext_tb_rate_set_i, ext_tb_active_o;
  idf_pkg::idf_fam_t family_i;
  logic [15:0] line_i, counter_route_i, isolated_i, filt_en_i, sync_en_i;
  logic [15:0] line_o, cfg_err_o, seen_r;
  logic seen_clr;
  logic [47:0] width_sel_i;
  logic [31:0] custom_width_i, ext_tb_rate_i;
  int n_fail, total_checks, w_exp[16], len_a[16];
  // ****************************************
  // Design, far side and clock
  // ****************************************
  input_debounce_filter input_debounce_filter_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .family_i(family_i), .line_i(line_i), .counter_route_i(counter_route_i),
    .isolated_i(isolated_i), .filt_en_i(filt_en_i), .sync_en_i(sync_en_i),
    .width_sel_i(width_sel_i), .custom_width_i(custom_width_i), .ext_tb_i(ext_tb_i),
    .ext_tb_src_en_i(ext_tb_src_en_i), .ext_tb_rate_set_i(ext_tb_rate_set_i),
    .ext_tb_rate_i(ext_tb_rate_i), .line_o(line_o), .cfg_err_o(cfg_err_o),
    .ext_tb_active_o(ext_tb_active_o));
  idf_sig_src idf_sig_src_i (.ref_clk_i(ref_clk_i), .line_o(line_i), .ext_tb_o(ext_tb_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Sticky record of any high level per output line
  initial seen_r = 16'h0000;
  always @(posedge ref_clk_i) seen_r <= seen_clr ? 16'h0000 : (seen_r | line_o);
  // ****************************************
  // Expectations and checks
  // ****************************************
  function automatic int cyc(input logic [31:0] ps);
    return int'(ps / `IDF_CLK_PERIOD_PS);
  endfunction : cyc
  // Pass width in clocks, 0 where the line is not filtered
  function automatic int width_of(input int g);
    int s;
    s = int'(width_sel_i[3*g +: 3]);
    if (isolated_i[g] && !filt_en_i[g]) return cyc(`IDF_W_ISO_PS);
    if (!filt_en_i[g] || sync_en_i[g]) return 0;
    if (family_i == idf_pkg::IDF_FAM_LOWER) begin
      if (!counter_route_i[g]) return 0;
      return s == 0 ? cyc(`IDF_W_LT0_PS) : s == 1 ? cyc(`IDF_W_LT1_PS) : cyc(`IDF_W_LT2_PS);
    end
    case (s)
      0: return cyc(`IDF_W_TD0_PS);
      1: return cyc(`IDF_W_TD1_PS);
      2: return cyc(`IDF_W_TD2_PS);
      3: return cyc(`IDF_W_TD3_PS);
      default: ;
    endcase
    // Ticks of the free timebase come every 4 clocks
    if (ext_tb_src_en_i && ext_tb_rate_set_i) return int'(ext_tb_rate_i) * 4;
    return custom_width_i == 32'h0000_0000 ? 1 : int'(custom_width_i);
  endfunction : width_of
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : check
  // Pulse every line once; rej lines get at most half their width
  task automatic run_set(input logic [15:0] rej);
    int mw;
    mw = 0;
    for (int g = 0; g < 16; g++) begin
      w_exp[g] = width_of(g);
      if (w_exp[g] > mw) mw = w_exp[g];
      if (w_exp[g] == 0) len_a[g] = 2 + $urandom % 3;
      else if (rej[g]) len_a[g] = w_exp[g] / 2 - $urandom % 3;
      else len_a[g] = w_exp[g] + 8 + $urandom % 4;
    end
    repeat (4) @(posedge ref_clk_i);
    #1 seen_clr = 1'b1;
    @(posedge ref_clk_i);
    #1 seen_clr = 1'b0;
    idf_sig_src_i.burst(len_a);
    // Long enough for the slowest filtered falling edge to land
    repeat (mw + 40) @(posedge ref_clk_i);
    #1;
    for (int g = 0; g < 16; g++) begin
      check(seen_r[g], (w_exp[g] == 0) || !rej[g], "pulse");
      check(line_o[g], 1'b0, "idle");
      check(cfg_err_o[g], filt_en_i[g] & sync_en_i[g], "conflict");
    end
  endtask : run_set
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic sel_all(input int modv, input logic rnd);
    for (int g = 0; g < 10; g++) width_sel_i[3*g +: 3] = 3'(rnd ? $urandom % 5 : g % modv);
  endtask : sel_all
  // Hang guard, well beyond the longest planned run
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_fail++;
    tally_and_finish();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(44887));
    rst_b_i = 1'b0;
    seen_clr = 1'b0;
    family_i = idf_pkg::IDF_FAM_TIMER;
    counter_route_i = 16'hFFFF;
    isolated_i = 16'h8000;
    filt_en_i = 16'h13FF;
    sync_en_i = 16'h3000;
    width_sel_i = 48'h0000_0000_0000;
    custom_width_i = 32'(10 + $urandom % 30);
    ext_tb_src_en_i = 1'b0;
    ext_tb_rate_set_i = 1'b0;
    ext_tb_rate_i = 32'h0000_0005;
    sel_all(5, 1'b0);
    repeat (3) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    run_set(16'h83E0);
    run_set(16'h03E0);
    filt_en_i[15] = 1'b1;
    repeat (3) begin
      custom_width_i = 32'(8 + $urandom % 33);
      sel_all(5, 1'b1);
      run_set(16'($urandom) & 16'h83FF);
    end
    family_i = idf_pkg::IDF_FAM_LOWER;
    counter_route_i = 16'hF3FF;
    filt_en_i = 16'h8FFF;
    sync_en_i = 16'h0000;
    sel_all(2, 1'b0);
    run_set(16'($urandom) & 16'h83FF);
    family_i = idf_pkg::IDF_FAM_TIMER;
    filt_en_i = 16'h83FF;
    sel_all(5, 1'b0);
    ext_tb_src_en_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 check(ext_tb_active_o, 1'b0, "source only");
    ext_tb_rate_set_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 check(ext_tb_active_o, 1'b1, "source and rate");
    run_set(16'($urandom) & 16'h83FF);
    tally_and_finish();
  end
endmodule : testbench
